// ### rtl/mrv_cfg.svh
// Constants for the register value handler: register offsets, field
// positions, reset values and timing counts. Definitions only.
`ifndef MRV_CFG_SVH
`define MRV_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets (word addresses on the holding-register space)
// ----------------------------------------------------------------------
`define MRV_SEL_BASE      16'h0500
`define MRV_DATA_BASE     16'h0504
`define MRV_DATA_LAST     16'h0553
`define MRV_CTL_XFER_BASE 16'h006E
`define MRV_CTL_BASE      16'h0076
`define MRV_CTL_LAST      16'h00C5
`define MRV_NUM_CH        4
`define MRV_NUM_ITEMS     20
`define MRV_NUM_AREAS     8

// ----------------------------------------------------------------------
// Item indices with special scaling or access
// ----------------------------------------------------------------------
`define MRV_ITEM_LBA_TIME 4
`define MRV_ITEM_SETPOINT 6
`define MRV_ITEM_INT_HEAT 8
`define MRV_ITEM_DER_HEAT 9
`define MRV_ITEM_CTL_RESP 10
`define MRV_ITEM_INT_COOL 12
`define MRV_ITEM_DER_COOL 13
`define MRV_ITEM_UNUSED   19

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define MRV_ITEM_DEFAULT  16'h0000
`define MRV_MAX_AREA      16'h0007
`define MRV_MAX_TEMP_DP   3'h1
`define MRV_MAX_VI_DP     3'h4
`define MRV_MAX_TIME_DP   1'h1

// ----------------------------------------------------------------------
// Timing: inter-message gap of 24 bit times
// ----------------------------------------------------------------------
`define MRV_GAP_BITS      24

`endif

// ### rtl/mrv_pkg.sv
// Types shared by the register value handler.
// Assumes mrv_cfg.svh is on the include path.
package mrv_pkg;

  typedef enum logic [1:0] {
    MRV_IDLE  = 2'b00,
    MRV_RDATA = 2'b01,
    MRV_WDONE = 2'b10,
    MRV_ERR   = 2'b11
  } mrv_state_t;

  typedef enum logic [1:0] {
    MRV_SCALE_DP   = 2'b00,
    MRV_SCALE_FIX3 = 2'b01,
    MRV_SCALE_ITD  = 2'b10,
    MRV_SCALE_XFER = 2'b11
  } mrv_scale_t;

endpackage

// ### rtl/mrv_scaler.sv
// Fixed-point to transfer-integer scaler.
// Assumes magnitude in thousandths of a unit and a combinational use.
`timescale 1ns/1ps
`default_nettype none
module mrv_scaler
  import mrv_pkg::*;
(
  // Value in thousandths
  input  wire logic [23:0] milliMag,
  input  wire logic        negative,
  // Decimal places, 0..4
  input  wire logic [2:0]  decPlaces,
  // Result word
  output logic      [15:0] wordOut
);
  logic [31:0] scaled;

  // Multiply by 10^dp, then divide out the thousandths
  always_comb begin
    case (decPlaces)
      3'h0: scaled = 32'(milliMag) / 32'h0000_03E8;
      3'h1: scaled = 32'(milliMag) / 32'h0000_0064;
      3'h2: scaled = 32'(milliMag) / 32'h0000_000A;
      3'h3: scaled = 32'(milliMag);
      default: scaled = 32'(milliMag) * 32'h0000_000A;
    endcase
    // Zero minus magnitude for negatives
    wordOut = negative ? 16'h0000 - scaled[15:0] : scaled[15:0];
  end
endmodule
`default_nettype wire

// ### rtl/mrv_handler.sv
// Register value handler: memory areas, scaling, access filtering.
// Assumes a frame layer supplies decoded requests on sys_clk and takes
// answers back; bytes are serialised by that layer high byte first.
// Requests are spaced at least three cycles apart; an extra strobe while
// an answer is pending is dropped without a reply.
//
// Summary of operation
// - Every value is a 16-bit word
// - Fractions scaled by ten to decimal places
// - Ratio parameters use three fixed places
// - Integral/derivative times use selectable zero/one place
// - Transfer times use own zero/one selection
// - Input type bounds measured-value decimal places
// - Negatives sent as two's complement
// - Control and setting areas differ in address
// - Out-of-range address answers with error
// - Unused item reads return default
// - Unused item writes silently dropped
// - Bad values rejected, good ones stored
// - Read-only writes silently ignored
// - Eight areas, one active per channel
// - Other areas accessible per channel
// - Selector maps area into data window
`timescale 1ns/1ps
`default_nettype none
`include "mrv_cfg.svh"
module mrv_handler
  import mrv_pkg::*;
#(
  parameter int NUM_CH    = `MRV_NUM_CH,
  parameter int NUM_AREAS = `MRV_NUM_AREAS,
  parameter int NUM_ITEMS = `MRV_NUM_ITEMS
)(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Request from frame layer
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic [15:0] reqAddr,
  input  wire logic [15:0] reqData,
  // Fixed-point value to encode
  input  wire logic        encValid,
  input  wire logic [23:0] encMilli,
  input  wire logic        encNeg,
  input  wire logic [1:0]  encKind,
  // Configuration
  input  wire logic        inputIsTemp,
  input  wire logic [2:0]  inputDecPlaces,
  input  wire logic        intDerDecPlace,
  input  wire logic        xferDecPlace,
  input  wire logic [3:0]  readOnlyItems,
  // Answer to frame layer
  output logic             rspValid,
  output logic             rspError,
  output logic [15:0]      rspData,
  output logic [7:0]       rspHighByte,
  output logic [7:0]       rspLowByte,
  // Encoder result
  output logic             encDone,
  output logic [15:0]      encWord,
  // Active areas, three bits per channel
  output logic [11:0]      activeAreas
);

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  // Item memory stays outside the state struct: it is an array, written
  // one word per cycle, and would bloat the struct copy otherwise.
  logic [15:0] itemMem [NUM_CH*NUM_AREAS*NUM_ITEMS];

  // Flat word index over channel, area and item
  localparam int IDX_W = $clog2(NUM_CH*NUM_AREAS*NUM_ITEMS);

  typedef struct packed {
    mrv_state_t  state;
    logic [11:0] selArea;
    logic [11:0] ctlArea;
    logic        rspValid;
    logic        rspError;
    logic [15:0] rspData;
    logic [15:0] pend;
    logic        encDone;
    logic [15:0] encWord;
  } mrv_regs_t;

  mrv_regs_t cur_r;
  mrv_regs_t cur_nxt;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  logic        isSel;
  logic        isData;
  logic        isXfer;
  logic        isCtl;
  logic [1:0]  ch;
  logic [4:0]  item;
  logic [2:0]  area;
  logic [15:0] off;
  logic [IDX_W-1:0] memIdx;
  logic        itemUnused;
  logic        itemRo;
  logic        valueOk;
  logic        doStore;

  always_comb begin
    isSel  = 1'b0;
    isData = 1'b0;
    isXfer = 1'b0;
    isCtl  = 1'b0;
    off    = 16'h0000;
    if (reqAddr >= `MRV_SEL_BASE && reqAddr < `MRV_DATA_BASE) begin
      isSel = 1'b1;
      off   = reqAddr - `MRV_SEL_BASE;
    end else if (reqAddr >= `MRV_DATA_BASE && reqAddr <= `MRV_DATA_LAST) begin
      isData = 1'b1;
      off    = reqAddr - `MRV_DATA_BASE;
    end else if (reqAddr >= `MRV_CTL_XFER_BASE
                 && reqAddr < `MRV_CTL_XFER_BASE + 16'h0004) begin
      isXfer = 1'b1;
      off    = reqAddr - `MRV_CTL_XFER_BASE;
    end else if (reqAddr >= `MRV_CTL_BASE && reqAddr <= `MRV_CTL_LAST) begin
      isCtl = 1'b1;
      off   = reqAddr - `MRV_CTL_BASE;
    end
    // Four channels interleave word by word: the low two offset bits pick
    // the channel and the next five the item
    ch   = off[1:0];
    item = off[6:2];
    // Data window uses selected area, control window the active one
    area = isCtl ? cur_r.ctlArea[3*ch +: 3]
                 : cur_r.selArea[3*ch +: 3];
    memIdx = IDX_W'((32'(ch) * 32'(NUM_AREAS) + 32'(area))
                    * 32'(NUM_ITEMS) + 32'(item));
    itemUnused = (item == 5'(`MRV_ITEM_UNUSED));
    // Area numbers above 7 are out of range
    valueOk = (isSel || isXfer) ? (reqData <= `MRV_MAX_AREA) : 1'b1;
  end

  // --------------------------------------------------------------------
  // Store filter
  // --------------------------------------------------------------------
  // Rejected writes still get a normal answer; the master has to read the
  // word back to learn whether it was kept.
  always_comb begin
    case (item)
      5'(`MRV_ITEM_INT_HEAT): itemRo = readOnlyItems[0];
      5'(`MRV_ITEM_DER_HEAT): itemRo = readOnlyItems[1];
      5'(`MRV_ITEM_INT_COOL): itemRo = readOnlyItems[2];
      5'(`MRV_ITEM_DER_COOL): itemRo = readOnlyItems[3];
      default:                itemRo = 1'b0;
    endcase
    doStore = reqValid && reqWrite && (cur_r.state == MRV_IDLE)
              && (isData || isCtl) && !itemUnused
              && !itemRo;
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  // The answer word is fixed at the taking edge, so the frame layer may
  // move the address on before the answer without corrupting it.
  logic [15:0] rdWord;

  always_comb begin
    if (isSel) begin
      rdWord = {13'h0000, cur_r.selArea[3*ch +: 3]};
    end else if (isXfer) begin
      rdWord = {13'h0000, cur_r.ctlArea[3*ch +: 3]};
    end else if (itemUnused) begin
      rdWord = `MRV_ITEM_DEFAULT;
    end else begin
      rdWord = itemMem[memIdx];
    end
  end

  // --------------------------------------------------------------------
  // Encoder: picks decimal places by parameter class
  // --------------------------------------------------------------------
  // Division truncates toward zero, so digits below the chosen places
  // are dropped, never rounded
  logic [2:0]  encPlaces;
  logic [15:0] encScaled;

  always_comb begin
    case (mrv_scale_t'(encKind))
      MRV_SCALE_FIX3: encPlaces = 3'h3;
      MRV_SCALE_ITD:  encPlaces = {2'b00, intDerDecPlace};
      MRV_SCALE_XFER: encPlaces = {2'b00, xferDecPlace};
      default: begin
        // Clamp to what the input type allows
        if (inputIsTemp) begin
          encPlaces = (inputDecPlaces > `MRV_MAX_TEMP_DP)
                      ? `MRV_MAX_TEMP_DP : inputDecPlaces;
        end else begin
          encPlaces = (inputDecPlaces > `MRV_MAX_VI_DP)
                      ? `MRV_MAX_VI_DP : inputDecPlaces;
        end
      end
    endcase
  end

  mrv_scaler u_scaler (
    .milliMag  (encMilli),
    .negative  (encNeg),
    .decPlaces (encPlaces),
    .wordOut   (encScaled)
  );

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  always_comb begin
    cur_nxt          = cur_r;
    cur_nxt.rspValid = 1'b0;
    cur_nxt.encDone  = 1'b0;
    if (encValid) begin
      cur_nxt.encDone = 1'b1;
      cur_nxt.encWord = encScaled;
    end
    case (cur_r.state)
      MRV_IDLE: begin
        if (reqValid) begin
          if (!(isSel || isData || isXfer || isCtl)) begin
            cur_nxt.state = MRV_ERR;
          end else if (!reqWrite) begin
            cur_nxt.pend  = rdWord;
            cur_nxt.state = MRV_RDATA;
          end else begin
            cur_nxt.pend  = reqData;
            // Bad values dropped, request still answered normally
            if (isSel && valueOk) begin
              cur_nxt.selArea[3*ch +: 3] = reqData[2:0];
            end
            if (isXfer && valueOk) begin
              cur_nxt.ctlArea[3*ch +: 3] = reqData[2:0];
            end
            cur_nxt.state = MRV_WDONE;
          end
        end
      end
      MRV_RDATA: begin
        cur_nxt.rspValid = 1'b1;
        cur_nxt.rspError = 1'b0;
        cur_nxt.rspData  = cur_r.pend;
        cur_nxt.state = MRV_IDLE;
      end
      MRV_WDONE: begin
        // Echo request data: write acknowledge carries no error
        cur_nxt.rspValid = 1'b1;
        cur_nxt.rspError = 1'b0;
        cur_nxt.rspData  = cur_r.pend;
        cur_nxt.state    = MRV_IDLE;
      end
      MRV_ERR: begin
        cur_nxt.rspValid = 1'b1;
        cur_nxt.rspError = 1'b1;
        cur_nxt.rspData  = 16'h0000;
        cur_nxt.state    = MRV_IDLE;
      end
      default: cur_nxt.state = MRV_IDLE;
    endcase
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  // Reset clears the area fields, so every channel starts on area 0
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // Memory has no reset; a real part loads it from backup storage
  always_ff @(posedge sys_clk) begin
    if (doStore) begin
      itemMem[memIdx] <= reqData;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // Every output is a field of the state register, with no logic after
  assign rspValid    = cur_r.rspValid;
  assign rspError    = cur_r.rspError;
  assign rspData     = cur_r.rspData;
  assign rspHighByte = cur_r.rspData[15:8];
  assign rspLowByte  = cur_r.rspData[7:0];
  assign encDone     = cur_r.encDone;
  assign encWord     = cur_r.encWord;
  assign activeAreas = cur_r.ctlArea;

endmodule
`default_nettype wire

// ### dv/mrv_handler_sva.sv
// Port checker for the register value handler, bound into mrv_handler.
// Assumes requests come at least three cycles apart, as the master sends.
`timescale 1ns/1ps
`default_nettype none
module mrv_handler_sva
  import mrv_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // Requests
  input wire logic        reqValid,
  input wire logic        reqWrite,
  input wire logic [15:0] reqAddr,
  input wire logic [15:0] reqData,
  input wire logic        encValid,
  input wire logic [23:0] encMilli,
  input wire logic        encNeg,
  input wire logic [1:0]  encKind,
  // Answers
  input wire logic        rspValid,
  input wire logic        rspError,
  input wire logic [15:0] rspData,
  input wire logic [7:0]  rspHighByte,
  input wire logic [7:0]  rspLowByte,
  input wire logic        encDone,
  input wire logic [15:0] encWord
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Busy window mirrors the handler so ignored strobes are not counted
  logic [1:0] busyCnt_r;
  logic       take;
  logic       inMap;
  assign take  = reqValid && (busyCnt_r == 2'h0);
  assign inMap = (reqAddr >= 16'h006E && reqAddr <= 16'h0071) ||
                 (reqAddr >= 16'h0076 && reqAddr <= 16'h00C5) ||
                 (reqAddr >= 16'h0500 && reqAddr <= 16'h0553);
  always_ff @(posedge sys_clk) begin
    if (!rst_b) busyCnt_r <= 2'h0;
    else if (take) busyCnt_r <= 2'h1;
    else if (busyCnt_r != 2'h0) busyCnt_r <= busyCnt_r - 2'h1;
  end
  property p_errRsp;
    take && !inMap |-> ##2 rspValid && rspError;
  endproperty
  a_errRsp: assert property (p_errRsp) else $error("no error");
  property p_okRsp;
    take && inMap |-> ##2 rspValid && !rspError;
  endproperty
  a_okRsp: assert property (p_okRsp) else $error("mapped error");
  property p_echo;
    take && reqWrite && inMap |-> ##2 rspData == $past(reqData, 2);
  endproperty
  a_echo: assert property (p_echo) else $error("echo wrong");
  property p_once;
    rspValid |=> !rspValid [*2];
  endproperty
  a_once: assert property (p_once) else $error("answer repeated");
  property p_bytes;
    rspValid |-> {rspHighByte, rspLowByte} == rspData;
  endproperty
  a_bytes: assert property (p_bytes) else $error("byte order");
  property p_encLat;
    encValid |=> encDone;
  endproperty
  a_encLat: assert property (p_encLat) else $error("encode late");
  property p_fix3;
    encValid && encKind == 2'h1 && encMilli < 24'h008000 |=>
      encWord == ($past(encNeg) ? 16'h0000 - 16'($past(encMilli))
                                : 16'($past(encMilli)));
  endproperty
  a_fix3: assert property (p_fix3) else $error("ratio");
  property p_encCause;
    encDone |-> $past(encValid);
  endproperty
  a_encCause: assert property (p_encCause) else $error("stray");
  c_write: cover property (take && reqWrite && inMap);
  c_error: cover property (take && !inMap);
  c_neg: cover property (encValid && encNeg);
endmodule
bind mrv_handler mrv_handler_sva mrv_handler_sva_i (.sys_clk(sys_clk),
  .rst_b(rst_b), .reqValid(reqValid), .reqWrite(reqWrite),
  .reqAddr(reqAddr), .reqData(reqData), .encValid(encValid),
  .encMilli(encMilli), .encNeg(encNeg), .encKind(encKind),
  .rspValid(rspValid), .rspError(rspError), .rspData(rspData),
  .rspHighByte(rspHighByte), .rspLowByte(rspLowByte),
  .encDone(encDone), .encWord(encWord));
`default_nettype wire

// ### dv/mrv_master.sv
// Host master model: one holding-register request at a time.
// Assumes the handler answers two edges after taking a request.
`timescale 1ns/1ps
`default_nettype none
module mrv_master #(
  parameter int GAP_CYC = 4  // Line gap in cycles; baud rate is not fixed
)(
  // Clock
  input wire logic        sys_clk,
  // Request
  output logic            reqValid,
  output logic            reqWrite,
  output logic [15:0]     reqAddr,
  output logic [15:0]     reqData,
  // Answer
  input wire logic        rspValid,
  input wire logic        rspError,
  input wire logic [15:0] rspData
);
  initial begin
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr  = 16'h0000;
    reqData  = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [15:0] a, d,
                      output logic [15:0] q, output logic e);
    int n;
    n = 0;
    @(posedge sys_clk);
    {reqValid, reqWrite, reqAddr, reqData} <= {1'b1, w, a, d};
    @(posedge sys_clk);
    reqValid <= 1'b0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (rspValid !== 1'b1 && n < 8);
    // A missing answer returns unknowns so every caller's compare trips
    if (rspValid === 1'b1) begin
      q = rspData;
      e = rspError;
    end else begin
      q = 16'hXXXX;
      e = 1'bX;
    end
    @(posedge sys_clk);
    // Released lines show the inverse so stale values are never trusted
    reqAddr <= ~a;
    reqData <= ~d;
    repeat (GAP_CYC - 1) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ### dv/tb_mrv_handler.sv
// Testbench for the register value handler: areas, filtering, scaling.
// Assumes the bound checker and the master model beside the handler.
`timescale 1ns/1ps
`default_nettype none
module tb_mrv_handler
  import mrv_pkg::*;
;
  logic sys_clk = 1'b0, rst_b = 1'b0, encValid = 1'b0, encNeg = 1'b0;
  logic inputIsTemp = 1'b0, intDerDecPlace = 1'b0, xferDecPlace = 1'b0;
  logic [23:0] encMilli = 24'h0;
  logic [1:0]  encKind = 2'h0;
  logic [2:0]  inputDecPlaces = 3'h0;
  logic [3:0]  readOnlyItems = 4'h0;
  logic        reqValid, reqWrite, rspValid, rspError, encDone, e;
  logic [15:0] reqAddr, reqData, rspData, encWord, q;
  logic [11:0] activeAreas;
  int          badCount = 0, checked = 0, cyc = 0;
  always #25 sys_clk = ~sys_clk;
  mrv_master mrv_master_i (.sys_clk(sys_clk), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
    .rspValid(rspValid), .rspError(rspError), .rspData(rspData));
  mrv_handler mrv_handler_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqData(reqData), .encValid(encValid), .encMilli(encMilli),
    .encNeg(encNeg), .encKind(encKind), .inputIsTemp(inputIsTemp),
    .inputDecPlaces(inputDecPlaces), .intDerDecPlace(intDerDecPlace),
    .xferDecPlace(xferDecPlace), .readOnlyItems(readOnlyItems),
    .rspValid(rspValid), .rspError(rspError), .rspData(rspData),
    .rspHighByte(), .rspLowByte(), .encDone(encDone), .encWord(encWord),
    .activeAreas(activeAreas));
  task automatic giveVerdict;
    if (badCount == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, d);
    mrv_master_i.xfer(1'b1, a, d, q, e);
    chk({15'h0, e}, 16'h0000);
  endtask
  task automatic rd(input logic [15:0] a, x);
    mrv_master_i.xfer(1'b0, a, 16'h0000, q, e);
    chk(q, x);
  endtask
  task automatic enc(input logic [5:0] c, input logic [1:0] k,
                     input logic [23:0] m, input logic n, input logic [15:0] x);
    @(posedge sys_clk);
    {inputIsTemp, inputDecPlaces, intDerDecPlace, xferDecPlace} <= c;
    {encValid, encKind, encMilli, encNeg} <= {1'b1, k, m, n};
    @(posedge sys_clk);
    encValid <= 1'b0;
    #1;
    chk({15'h0, encDone}, 16'h0001);
    chk(encWord, x);
  endtask
  task automatic tArea;
    wr(16'h0500, 16'h0002);
    wr(16'h0504, 16'h0032);
    rd(16'h0504, 16'h0032);
    wr(16'h0500, 16'h0003);
    wr(16'h051C, 16'hFF38);
    wr(16'h0501, 16'h0005);
    wr(16'h0505, 16'h0007);
    wr(16'h0500, 16'h0002);
    rd(16'h0504, 16'h0032);
    rd(16'h0505, 16'h0007);
    wr(16'h006E, 16'h0003);
    chk({4'h0, activeAreas}, 16'h0003);
    rd(16'h008E, 16'hFF38);
    wr(16'h0500, 16'h0009);
    rd(16'h0500, 16'h0002);
    wr(16'h008E, 16'h00C8);
    wr(16'h0500, 16'h0003);
    rd(16'h051C, 16'h00C8);
  endtask
  task automatic tErr;
    logic [15:0] bad [6] = '{16'h006D, 16'h0072, 16'h0075, 16'h00C6,
                             16'h04FF, 16'h0554};
    foreach (bad[i]) begin
      mrv_master_i.xfer(1'b0, bad[i], 16'h0000, q, e);
      chk({15'h0, e}, 16'h0001);
    end
  endtask
  task automatic tFilter;
    wr(16'h0550, 16'h1234);
    rd(16'h0550, 16'h0000);
    wr(16'h0524, 16'h0011);
    wr(16'h0538, 16'h0033);
    @(posedge sys_clk);
    readOnlyItems <= 4'h9;
    wr(16'h0524, 16'h0022);
    wr(16'h0538, 16'h0044);
    wr(16'h0528, 16'h0055);
    rd(16'h0524, 16'h0011);
    rd(16'h0538, 16'h0033);
    rd(16'h0528, 16'h0055);
  endtask
  task automatic tEnc;
    enc(6'h00, MRV_SCALE_FIX3, 24'd555, 1'b0, 16'h022B);
    enc(6'h00, MRV_SCALE_FIX3, 24'd1, 1'b1, 16'hFFFF);
    enc(6'h02, MRV_SCALE_ITD, 24'd240000, 1'b0, 16'h0960);
    enc(6'h00, MRV_SCALE_ITD, 24'd240000, 1'b0, 16'h00F0);
    enc(6'h01, MRV_SCALE_XFER, 24'd50000, 1'b0, 16'h01F4);
    enc(6'h00, MRV_SCALE_XFER, 24'd50000, 1'b0, 16'h0032);
    enc(6'h24, MRV_SCALE_DP, 24'd20000, 1'b1, 16'hFF38);
    enc(6'h30, MRV_SCALE_DP, 24'd1234, 1'b0, 16'h000C);
    enc(6'h10, MRV_SCALE_DP, 24'd1234, 1'b0, 16'h3034);
    enc(6'h00, MRV_SCALE_DP, 24'd20000, 1'b0, 16'h0014);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      badCount++;
      giveVerdict;
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    tArea;
    tErr;
    tFilter;
    tEnc;
    giveVerdict;
  end
endmodule
`default_nettype wire
